// ===== pkg/zsic_pkg.sv
// Shared constants for the zone status and input conditioning block
package zsic_pkg;
    // ==========================================================
    // Register word offsets
    localparam logic [7:0] OFS_INPUT_MASK = 8'h22;
    localparam logic [7:0] OFS_INPUT_WORD = 8'h23;
    localparam logic [7:0] OFS_UP_STATUS = 8'h74;
    localparam logic [7:0] OFS_DN_STATUS = 8'hC4;
    localparam logic [7:0] OFS_TRACK_ONE = 8'hC9;
    localparam logic [7:0] OFS_TRACK_TWO = 8'hCA;

    // ==========================================================
    // Widths and field layout
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    localparam int PORT_CNT = 4;
    localparam int INPUT_CNT = 8;
    localparam int PIN3_LSB = 0;
    localparam int PIN4_LSB = 4;

    // ==========================================================
    // Status codes and reset values
    localparam logic [15:0] DN_CODE_WAKE = 16'h0004;
    localparam logic [15:0] DN_CODE_EXIT = 16'h0001;
    localparam logic [15:0] UP_CODE_HOLD = 16'h0005;
    localparam logic [15:0] UP_CODE_RELEASE = 16'h0001;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [7:0] INPUT_RESET = 8'h00;
endpackage

// ===== rtl/zsic_top.sv
// Neighbour status words, tracking words and sensor input conditioning
`timescale 1ns/1ps
// How it works
// [RULE1] Writing 4 to downstream status pulses a wake request to the downstream neighbour.
// [RULE2] Writing 1 to downstream status signals carton exit and, in host-controlled mode, hands over tracking.
// [RULE3] Writing 5 to upstream status tells upstream discharge zone to hold.
// [RULE4] Writing 1 to upstream status tells upstream discharge zone to release.
// [RULE5] Tracking words go downstream only in host-controlled mode, with the exit code.
// [RULE6] Mask bits 0-3 cover pin-3 inputs, bits 4-7 pin-4 inputs, same port order.
// [RULE7] Mask bits 8 to 15 are stored but never touch conditioning.
// [RULE8] Conditioned bit is the raw level, inverted where the mask bit is set.
// [RULE9] Each red and green indicator is lit exactly when its conditioned bit is one.
// [RULE10] Entering host-controlled mode clears the auto-configured mask.
// [RULE11] Auto-configuration loads the mask only in zone accumulation mode.
// [RULE12] Pin-4 drives green, pin-3 red; both lit on a port shows amber.
// [RULE13] Host must deliver its new mask before trusting conditioned bits.
// [RULE14] Inversion is combinational on synchronised inputs, registered next edge.
module zsic_top
    import zsic_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [REG_W-1:0] reg_wdata_i,
    output logic [REG_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Mode and auto-configuration
    input wire logic host_mode_i,
    input wire logic autocfg_load_i,
    input wire logic [REG_W-1:0] autocfg_mask_i,
    // Raw sensor and control port pins
    input wire logic [INPUT_CNT-1:0] raw_in_i,
    // Conditioned inputs and indicators
    output logic [INPUT_CNT-1:0] cond_in_o,
    output logic [PORT_CNT-1:0] led_red_o,
    output logic [PORT_CNT-1:0] led_green_o,
    output logic [PORT_CNT-1:0] led_amber_o,
    // Downstream neighbour
    output logic [REG_W-1:0] dn_status_o,
    output logic dn_wake_o,
    output logic dn_exit_o,
    output logic [REG_W-1:0] dn_track_one_o,
    output logic [REG_W-1:0] dn_track_two_o,
    // Upstream neighbour
    output logic [REG_W-1:0] up_status_o,
    output logic up_hold_o,
    output logic up_release_o
);

    // ==========================================================
    // Register storage
    logic [REG_W-1:0] input_mask;
    logic [REG_W-1:0] track_one;
    logic [REG_W-1:0] track_two;
    logic host_mode_q;
    logic [INPUT_CNT-1:0] pin_meta;
    logic [INPUT_CNT-1:0] pin_sync;

    // ==========================================================
    // Address decode
    // Strobe and address are passed in so each select wire follows both of them
    function automatic logic wr_hit(
        input logic wr,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        return wr && (addr == ofs);
    endfunction

    wire logic wr_mask = wr_hit(reg_wr_i, reg_addr_i, OFS_INPUT_MASK);
    wire logic wr_up = wr_hit(reg_wr_i, reg_addr_i, OFS_UP_STATUS);
    wire logic wr_dn = wr_hit(reg_wr_i, reg_addr_i, OFS_DN_STATUS);
    wire logic wr_trk1 = wr_hit(reg_wr_i, reg_addr_i, OFS_TRACK_ONE);
    wire logic wr_trk2 = wr_hit(reg_wr_i, reg_addr_i, OFS_TRACK_TWO);
    wire logic host_entry = host_mode_i && !host_mode_q;
    wire logic dn_is_wake = wr_dn && (reg_wdata_i == DN_CODE_WAKE);
    wire logic dn_is_exit = wr_dn && (reg_wdata_i == DN_CODE_EXIT);
    wire logic track_send = dn_is_exit && host_mode_i;

    // Only the low byte of the mask reaches the inputs; upper bits are inert
    wire logic [INPUT_CNT-1:0] mask_used = input_mask[INPUT_CNT-1:0]; // RULE7
    wire logic [INPUT_CNT-1:0] next_cond = pin_sync ^ mask_used; // RULE8 RULE14 RULE6

    wire logic [PORT_CNT-1:0] next_red = next_cond[PIN3_LSB +: PORT_CNT]; // RULE12
    wire logic [PORT_CNT-1:0] next_green = next_cond[PIN4_LSB +: PORT_CNT]; // RULE12

    logic [REG_W-1:0] next_rdata;
    always_comb begin
        unique case (reg_addr_i)
            OFS_INPUT_MASK: next_rdata = input_mask;
            OFS_INPUT_WORD: next_rdata = {{(REG_W-INPUT_CNT){1'b0}}, cond_in_o};
            OFS_UP_STATUS: next_rdata = up_status_o;
            OFS_DN_STATUS: next_rdata = dn_status_o;
            OFS_TRACK_ONE: next_rdata = track_one;
            OFS_TRACK_TWO: next_rdata = track_two;
            default: next_rdata = REG_RESET;
        endcase
    end

    // ==========================================================
    // Pin synchroniser, two stages before any logic
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_meta <= INPUT_RESET;
            pin_sync <= INPUT_RESET;
        end else begin
            pin_meta <= raw_in_i;
            pin_sync <= pin_meta;
        end
    end

    // ==========================================================
    // Input mask: host write beats the entry clear and auto-config load
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            input_mask <= REG_RESET;
            host_mode_q <= 1'b0;
        end else begin
            host_mode_q <= host_mode_i;
            if (wr_mask) begin
                input_mask <= reg_wdata_i;
            end else if (host_entry) begin
                input_mask <= REG_RESET; // RULE10
            end else if (autocfg_load_i && !host_mode_i) begin
                input_mask <= autocfg_mask_i; // RULE11
            end
        end
    end

    // ==========================================================
    // Conditioned word and indicators share one edge so they never disagree
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cond_in_o <= INPUT_RESET;
            led_red_o <= '0;
            led_green_o <= '0;
            led_amber_o <= '0;
        end else begin
            cond_in_o <= next_cond; // RULE14
            led_red_o <= next_red; // RULE9
            led_green_o <= next_green; // RULE9
            led_amber_o <= next_red & next_green; // RULE12
        end
    end

    // ==========================================================
    // Downstream status and tracking
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dn_status_o <= REG_RESET;
            dn_wake_o <= 1'b0;
            dn_exit_o <= 1'b0;
            track_one <= REG_RESET;
            track_two <= REG_RESET;
            dn_track_one_o <= REG_RESET;
            dn_track_two_o <= REG_RESET;
        end else begin
            dn_wake_o <= dn_is_wake; // RULE1
            dn_exit_o <= dn_is_exit; // RULE2
            if (wr_dn) begin
                dn_status_o <= reg_wdata_i;
            end
            if (wr_trk1) begin
                track_one <= reg_wdata_i;
            end
            if (wr_trk2) begin
                track_two <= reg_wdata_i;
            end
            // Outside host mode the words stay local and the neighbour sees old data
            if (track_send) begin
                dn_track_one_o <= track_one; // RULE5 RULE2
                dn_track_two_o <= track_two; // RULE5 RULE2
            end
        end
    end

    // ==========================================================
    // Upstream status, levels held until the next write
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            up_status_o <= REG_RESET;
            up_hold_o <= 1'b0;
            up_release_o <= 1'b0;
        end else if (wr_up) begin
            up_status_o <= reg_wdata_i;
            up_hold_o <= (reg_wdata_i == UP_CODE_HOLD); // RULE3
            up_release_o <= (reg_wdata_i == UP_CODE_RELEASE); // RULE4
        end
    end

    // ==========================================================
    // Read port, answer one cycle after the strobe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= REG_RESET;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    // ==========================================================
    // Assertions
    a_wake_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE1
        (reg_wr_i && reg_addr_i == OFS_DN_STATUS && reg_wdata_i == DN_CODE_WAKE)
        |=> dn_wake_o && dn_status_o == DN_CODE_WAKE)
        else $error("wake code did not pulse wake");

    a_exit_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE2
        dn_exit_o |-> $past(reg_wr_i) && $past(reg_addr_i) == OFS_DN_STATUS
        && $past(reg_wdata_i) == DN_CODE_EXIT)
        else $error("exit pulse without exit code");

    a_hold_level: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE3
        up_hold_o |-> up_status_o == UP_CODE_HOLD && !up_release_o)
        else $error("hold level disagrees with upstream word");

    a_release_level: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE4
        (up_status_o == UP_CODE_RELEASE) |-> up_release_o)
        else $error("release level missing");

    a_track_host_only: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE5
        $changed(dn_track_one_o) |-> $past(host_mode_i) && $past(dn_is_exit))
        else $error("tracking moved outside host exit write");

    a_cond_invert: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE8
        ##1 cond_in_o == ($past(pin_sync) ^ $past(input_mask[INPUT_CNT-1:0])))
        else $error("conditioned word wrong");

    a_upper_inert: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE7
        ($past(input_mask[INPUT_CNT-1:0]) == input_mask[INPUT_CNT-1:0]
        && $stable(pin_sync)) |=> $stable(cond_in_o))
        else $error("reserved mask bits affected inputs");

    a_led_match: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE9
        led_red_o == cond_in_o[PIN3_LSB +: PORT_CNT]
        && led_green_o == cond_in_o[PIN4_LSB +: PORT_CNT])
        else $error("indicator differs from input word");

    a_amber_both: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE12
        led_amber_o == (led_red_o & led_green_o))
        else $error("amber not red and green");

    a_entry_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE10
        (host_entry && !wr_mask) |=> input_mask == REG_RESET)
        else $error("mask not cleared on host entry");

    a_autocfg_block: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE11
        (host_mode_i && !wr_mask) |=> $stable(input_mask) || input_mask == REG_RESET)
        else $error("auto-config loaded in host mode");

    a_read_answer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");

    a_exit_forward: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE2
        (reg_wr_i && reg_addr_i == OFS_DN_STATUS && reg_wdata_i == DN_CODE_EXIT)
        |=> dn_exit_o && dn_status_o == DN_CODE_EXIT)
        else $error("exit code did not pulse exit");

    a_track_deliver: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE5
        (reg_wr_i && reg_addr_i == OFS_DN_STATUS && reg_wdata_i == DN_CODE_EXIT
        && host_mode_i) |=> dn_track_one_o == $past(track_one)
        && dn_track_two_o == $past(track_two))
        else $error("tracking words not delivered with exit");

    a_track_pair: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE5
        $changed(dn_track_two_o) |-> $past(host_mode_i) && $past(dn_is_exit))
        else $error("second tracking word moved outside host exit write");

    a_release_only: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE4
        up_release_o |-> up_status_o == UP_CODE_RELEASE && !up_hold_o)
        else $error("release level disagrees with upstream word");

    a_hold_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE3
        (up_status_o == UP_CODE_HOLD) |-> up_hold_o)
        else $error("hold level missing");

    a_mask_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (reg_wr_i && reg_addr_i == OFS_INPUT_MASK) |=> input_mask == $past(reg_wdata_i))
        else $error("mask write lost");

    a_sync_delay: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE14
        ##2 pin_sync == $past(raw_in_i, 2))
        else $error("pin synchroniser depth wrong");

    c_hold: cover property (@(posedge clk_i) disable iff (sys_rst_i) up_hold_o);
    c_wake: cover property (@(posedge clk_i) disable iff (sys_rst_i) dn_wake_o);
    c_track_send: cover property (@(posedge clk_i) disable iff (sys_rst_i) track_send);
    c_amber: cover property (@(posedge clk_i) disable iff (sys_rst_i) |led_amber_o);
    c_entry: cover property (@(posedge clk_i) disable iff (sys_rst_i) host_entry);

endmodule // zsic_top

// ===== verif/zsic_host_model.sv
// Host controller model driving the register port
`timescale 1ns/1ps
module zsic_host_model
    import zsic_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Register port
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [ADDR_W-1:0] reg_addr_o,
    output logic [REG_W-1:0] reg_wdata_o,
    input wire logic [REG_W-1:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 16'h0000;
    end
    // ==========================================================
    // Bus cycles start on a falling edge so strobes never bounce in one step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d, output logic v);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
        v = reg_rvalid_i;
    endtask
    // Inputs are not trusted until the new mask has taken effect
    task automatic mask_set(input logic [REG_W-1:0] m);
        wr(OFS_INPUT_MASK, m);
        repeat (3) @(negedge clk_i);
    endtask
endmodule // zsic_host_model

// ===== verif/zsic_top_tb.sv
// Self-checking bench for the zone status and input conditioning block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module zsic_top_tb;
    import zsic_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic host_mode_i = 1'b0;
    logic autocfg_load_i = 1'b0;
    logic [15:0] autocfg_mask_i = 16'h0000;
    logic [7:0] raw_in_i = 8'h00;
    logic reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, dn_status_o, dn_track_one_o, dn_track_two_o, up_status_o;
    logic [7:0] cond_in_o;
    logic [3:0] led_red_o, led_green_o, led_amber_o;
    logic dn_wake_o, dn_exit_o, up_hold_o, up_release_o;
    int n_errors = 0;
    int checked = 0;
    int seed = 42;
    int cycles = 0;
    int mdl_cond;
    int trk_q[$];
    logic [15:0] up_codes[3] = '{16'h0005, 16'h0001, 16'h0003};

    always #12.5 clk_i = ~clk_i;

    zsic_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .reg_rvalid_o(reg_rvalid), .host_mode_i(host_mode_i), .autocfg_load_i(autocfg_load_i),
        .autocfg_mask_i(autocfg_mask_i), .raw_in_i(raw_in_i), .cond_in_o(cond_in_o),
        .led_red_o(led_red_o), .led_green_o(led_green_o), .led_amber_o(led_amber_o),
        .dn_status_o(dn_status_o), .dn_wake_o(dn_wake_o), .dn_exit_o(dn_exit_o),
        .dn_track_one_o(dn_track_one_o), .dn_track_two_o(dn_track_two_o),
        .up_status_o(up_status_o), .up_hold_o(up_hold_o), .up_release_o(up_release_o));

    zsic_host_model u_host (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata),
        .reg_rvalid_i(reg_rvalid));

    task automatic give_verdict();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Whole run is about 140 cycles; this only cuts a hang
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        logic [15:0] d;
        logic v;
        logic [7:0] r;
        logic [15:0] m;
        repeat (8) @(negedge clk_i);
        sys_rst_i = 1'b0;
        // ==========================================================
        // Mask ownership across modes
        autocfg_mask_i = 16'h0050;
        autocfg_load_i = 1'b1;
        @(negedge clk_i);
        autocfg_load_i = 1'b0;
        u_host.rd(OFS_INPUT_MASK, d, v);
        `CHK(d, 16'h0050)
        host_mode_i = 1'b1;
        autocfg_load_i = 1'b1;
        @(negedge clk_i);
        autocfg_load_i = 1'b0;
        u_host.rd(OFS_INPUT_MASK, d, v);
        `CHK(d, 16'h0000)
        // A load while the host owns the mask must leave it alone
        autocfg_mask_i = 16'h00A0;
        autocfg_load_i = 1'b1;
        @(negedge clk_i);
        autocfg_load_i = 1'b0;
        u_host.rd(OFS_INPUT_MASK, d, v);
        `CHK(d, 16'h0000)
        // ==========================================================
        // Random pins against random masks
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m = 16'($random(seed));
            u_host.mask_set(m);
            mdl_cond = (int'(r) ^ int'(m)) & 32'hFF;
            r = 8'($random(seed));
            raw_in_i = r;
            repeat (2) @(negedge clk_i);
            `CHK(cond_in_o, 8'(mdl_cond))
            @(negedge clk_i);
            mdl_cond = (int'(r) ^ int'(m)) & 32'hFF;
            `CHK(cond_in_o, 8'(mdl_cond))
            `CHK(led_red_o, 4'(mdl_cond))
            `CHK(led_green_o, 4'(mdl_cond >> 4))
            `CHK(led_amber_o, 4'(mdl_cond & (mdl_cond >> 4)))
            u_host.rd(OFS_INPUT_WORD, d, v);
            `CHK(d, 16'(mdl_cond))
            u_host.rd(OFS_INPUT_MASK, d, v);
            `CHK(d, m)
        end
        // ==========================================================
        // Neighbour status words
        foreach (up_codes[k]) begin
            u_host.wr(OFS_UP_STATUS, up_codes[k]);
            `CHK(up_status_o, up_codes[k])
            `CHK(up_hold_o, 1'(up_codes[k] == 16'h0005))
            `CHK(up_release_o, 1'(up_codes[k] == 16'h0001))
        end
        u_host.wr(OFS_DN_STATUS, 16'h0004);
        `CHK({dn_wake_o, dn_exit_o, dn_status_o}, {2'b10, 16'h0004})
        @(negedge clk_i);
        `CHK(dn_wake_o, 1'b0)
        // Tracking is delivered in host mode only, so the first pair must stick
        for (int j = 0; j < 2; j++) begin
            host_mode_i = 1'(j == 0);
            trk_q.push_back($random(seed) & 32'hFFFF);
            trk_q.push_back($random(seed) & 32'hFFFF);
            u_host.wr(OFS_TRACK_ONE, 16'(trk_q[2 * j]));
            u_host.wr(OFS_TRACK_TWO, 16'(trk_q[2 * j + 1]));
            u_host.wr(OFS_DN_STATUS, 16'h0001);
            `CHK({dn_wake_o, dn_exit_o, dn_status_o}, {2'b01, 16'h0001})
            `CHK(dn_track_one_o, 16'(trk_q[0]))
            `CHK(dn_track_two_o, 16'(trk_q[1]))
        end
        // Words kept locally still read back as written
        u_host.rd(OFS_TRACK_ONE, d, v);
        `CHK(d, 16'(trk_q[2]))
        u_host.rd(OFS_DN_STATUS, d, v);
        `CHK(d, 16'h0001)
        u_host.rd(8'h10, d, v);
        `CHK({v, d}, {1'b1, 16'h0000})
        give_verdict();
    end
endmodule // zsic_top_tb
